// ==== hw/fpg_guard.sv ====
// Top of the flash program guard: key register, sector address registers, mode decode
//
// Summary of operation
// - Reset clears the key register, so program mode starts disabled.
// - Program mode is enabled only while the key holds 10100101b.
// - Writing any other key value disables program mode.
// - With program mode disabled, every erase and program request is blocked.
// - Sector high register gives sector base address bits 15 to 8.
// - Low register bit 7 gives address bit 7; bits 6 to 0 ignored.
// - Flash holds 384 sectors of 128 bytes each.
// - Three 8-bit read/write registers at F6h, F7h, F8h, reset to zero.
// - Control mode bits 7 to 4: 0101 program, 1010 erase, 0110 hard lock.
`timescale 1ns/1ps
module fpg_guard
  import fpg_pkg::*;
#(
  parameter int SECTOR_COUNT = FPG_SECTOR_COUNT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [7:0] flash_op_control,
  input wire logic flash_op_start,
  output logic user_program_mode,
  output logic [FPG_ADDR_W-1:0] sector_base_addr,
  output logic sector_in_range,
  output fpg_op_t op_select,
  output logic op_allow,
  output logic op_blocked
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] sector_base_high;
  logic [7:0] sector_base_low;
  logic [7:0] self_program_key;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  fpg_sfr_reg #(.OFFSET(FPG_SECTOR_BASE_HIGH_OFS)) u_high (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .value(sector_base_high)
  );

  fpg_sfr_reg #(.OFFSET(FPG_SECTOR_BASE_LOW_OFS)) u_low (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .value(sector_base_low)
  );

  // Key register clears on reset and takes every written value
  fpg_sfr_reg #(.OFFSET(FPG_SELF_PROGRAM_KEY_OFS)) u_key (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .value(self_program_key)
  );

  // ****************************************
  // Read path
  // ****************************************
  wire logic hit_high = (sfr_addr == FPG_SECTOR_BASE_HIGH_OFS);
  wire logic hit_low = (sfr_addr == FPG_SECTOR_BASE_LOW_OFS);
  wire logic hit_key = (sfr_addr == FPG_SELF_PROGRAM_KEY_OFS);

  assign sfr_hit = hit_high || hit_low || hit_key;
  assign rdata_d = !sfr_rd ? rdata_q :
                   hit_high ? sector_base_high :
                   hit_low ? sector_base_low :
                   hit_key ? self_program_key : 8'h00;
  assign sfr_rdata = rdata_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= FPG_REG_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Mode and sector address
  // ****************************************
  assign user_program_mode = (self_program_key == FPG_UNLOCK_KEY);

  // Low seven bits forced to zero regardless of what software wrote
  assign sector_base_addr = {sector_base_high, sector_base_low[FPG_LOW_BIT_POS],
                             7'h00};

  // Sector index is address bits 15..7
  wire logic [8:0] sector_index = {sector_base_high, sector_base_low[FPG_LOW_BIT_POS]};
  assign sector_in_range = (32'(sector_index) < SECTOR_COUNT);

  // ****************************************
  // Operation decode and guard
  // ****************************************
  wire logic [3:0] mode_field = flash_op_control[FPG_MODE_MSB:FPG_MODE_LSB];

  always_comb begin
    case (mode_field)
      FPG_MODE_PROGRAM: op_select = FPG_OP_PROGRAM;
      FPG_MODE_ERASE: op_select = FPG_OP_ERASE;
      FPG_MODE_HARD_LOCK: op_select = FPG_OP_HARD_LOCK;
      default: op_select = FPG_OP_NONE;
    endcase
  end

  wire logic op_req = flash_op_start && (op_select != FPG_OP_NONE);
  assign op_allow = op_req && user_program_mode && sector_in_range;
  assign op_blocked = op_req && !op_allow;
endmodule : fpg_guard

// ==== hw/fpg_pkg.sv ====
// Package with register offsets, reset values and codes of the flash program guard
package fpg_pkg;
  localparam logic [7:0] FPG_SECTOR_BASE_HIGH_OFS = 8'hf6;
  localparam logic [7:0] FPG_SECTOR_BASE_LOW_OFS = 8'hf7;
  localparam logic [7:0] FPG_SELF_PROGRAM_KEY_OFS = 8'hf8;
  localparam logic [7:0] FPG_FLASH_OP_CONTROL_OFS = 8'hf9;
  localparam logic [7:0] FPG_REG_RESET = 8'h00;
  localparam logic [7:0] FPG_UNLOCK_KEY = 8'ha5;
  localparam int FPG_ADDR_W = 16;
  localparam int FPG_SECTOR_BYTES = 128;
  localparam int FPG_SECTOR_COUNT = 384;
  localparam int FPG_LOW_BIT_POS = 7;
  localparam logic [3:0] FPG_MODE_PROGRAM = 4'h5;
  localparam logic [3:0] FPG_MODE_ERASE = 4'ha;
  localparam logic [3:0] FPG_MODE_HARD_LOCK = 4'h6;
  localparam int FPG_MODE_MSB = 7;
  localparam int FPG_MODE_LSB = 4;
  typedef enum logic [1:0] {FPG_OP_NONE, FPG_OP_PROGRAM, FPG_OP_ERASE, FPG_OP_HARD_LOCK} fpg_op_t;
endpackage : fpg_pkg

// ==== hw/fpg_sfr_reg.sv ====
// One 8-bit read/write special function register with reset to zero
`timescale 1ns/1ps
module fpg_sfr_reg
  import fpg_pkg::*;
#(
  parameter logic [7:0] OFFSET = 8'h00
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] value
);
  logic [7:0] value_q;
  logic [7:0] value_d;
  wire logic hit = sfr_wr && (sfr_addr == OFFSET);

  assign value_d = hit ? sfr_wdata : value_q;
  assign value = value_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value_q <= FPG_REG_RESET;
    end else begin
      value_q <= value_d;
    end
  end
endmodule : fpg_sfr_reg

// ==== bench/fpg_guard_monitor.sv ====
// Checker of the flash program guard ports
`timescale 1ns/1ps
module fpg_guard_monitor import fpg_pkg::*; #(parameter int SECTOR_COUNT = FPG_SECTOR_COUNT) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic flash_op_start,
  input wire logic user_program_mode,
  input wire logic [FPG_ADDR_W-1:0] sector_base_addr,
  input wire logic sector_in_range,
  input wire fpg_op_t op_select,
  input wire logic op_blocked
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence key_wr; sfr_wr && sfr_addr == 8'hf8; endsequence
  rst_key_a: assert property ($fell(sys_rst) |-> !user_program_mode)
    else $error("mode set after reset");
  key_open_a: assert property (key_wr ##0 sfr_wdata == 8'ha5 |=> user_program_mode)
    else $error("unlock ignored");
  key_shut_a: assert property (key_wr ##0 sfr_wdata != 8'ha5 |=> !user_program_mode)
    else $error("lock ignored");
  op_guard_a: assert property (flash_op_start && op_select != FPG_OP_NONE &&
    !user_program_mode |-> op_blocked) else $error("op not blocked");
  high_byte_a: assert property (sfr_wr && sfr_addr == 8'hf6 |=>
    sector_base_addr[15:8] == $past(sfr_wdata)) else $error("high byte wrong");
  low_bit_a: assert property (sfr_wr && sfr_addr == 8'hf7 |=>
    sector_base_addr[7] == $past(sfr_wdata[7])) else $error("bit 7 wrong");
  low_zero_a: assert property (sector_base_addr[6:0] == 7'h00)
    else $error("low bits set");
  sector_range_a: assert property (sector_in_range ==
    (sector_base_addr[15:7] < SECTOR_COUNT)) else $error("range wrong");
endmodule : fpg_guard_monitor
bind fpg_guard fpg_guard_monitor #(.SECTOR_COUNT(SECTOR_COUNT)) u_fpg_guard_monitor (
  .clk(clk),
  .sys_rst(sys_rst),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata),
  .flash_op_start(flash_op_start),
  .user_program_mode(user_program_mode),
  .sector_base_addr(sector_base_addr),
  .sector_in_range(sector_in_range),
  .op_select(op_select),
  .op_blocked(op_blocked)
);

// ==== bench/tb_top.sv ====
// Testbench of the flash program guard
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t mismatch", $time); end end
module tb_top import fpg_pkg::*; ;
  logic clk = 1'h0, sys_rst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0, flash_op_start = 1'h1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, flash_op_control = 8'h51, sfr_rdata;
  logic sfr_hit, user_program_mode, sector_in_range, op_allow, op_blocked;
  logic [FPG_ADDR_W-1:0] sector_base_addr;
  fpg_op_t op_select;
  int bad_count = 0, n_checks = 0;
  logic [7:0] kv [5] = '{8'h01, 8'ha4, 8'ha5, 8'ha6, 8'hff};
  logic [3:0] mv [4] = '{4'h3, 4'h5, 4'ha, 4'h6};
  always #2 clk = ~clk;
  fpg_guard u_fpg_guard (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .flash_op_control(flash_op_control),
    .flash_op_start(flash_op_start),
    .user_program_mode(user_program_mode),
    .sector_base_addr(sector_base_addr),
    .sector_in_range(sector_in_range),
    .op_select(op_select),
    .op_allow(op_allow),
    .op_blocked(op_blocked)
  );
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, w, !w};
    @(negedge clk);
    {sfr_wr, sfr_rd} = 2'h0;
    `CHK(sfr_hit, a >= 8'hf6 && a <= 8'hf8)
    if (!w) `CHK(sfr_rdata, d)
  endtask : acc
  task automatic tally_and_finish(input logic hung);
    bad_count += int'(hung);
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'h0;
    acc(1'h0, 8'hf8, 8'h00);
    $display("reset value test done");
    foreach (kv[i]) begin
      acc(1'h1, 8'hf8, kv[i]);
      `CHK(user_program_mode, kv[i] == 8'ha5)
      `CHK(op_blocked, kv[i] != 8'ha5)
    end
    $display("key test done");
    acc(1'h1, 8'hf8, 8'ha5);
    foreach (mv[m]) begin
      flash_op_control = {mv[m], 4'h1};
      @(negedge clk);
      `CHK(op_select, fpg_op_t'(m))
      `CHK(op_allow, m != 0)
    end
    $display("mode decode test done");
    for (int s = 0; s < 2; s++) begin
      acc(1'h1, 8'hf6, s ? 8'hc0 : 8'hbf);
      acc(1'h1, 8'hf7, s ? 8'h00 : 8'hff);
      acc(1'h0, 8'hf7, s ? 8'h00 : 8'hff);
      `CHK(sector_base_addr, s ? 16'hc000 : 16'hbf80)
      `CHK(op_blocked, s == 1)
      `CHK(sector_in_range, s == 0)
    end
    $display("sector test done");
    acc(1'h0, 8'hf9, 8'h00);
    sys_rst = 1'h1;
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    acc(1'h0, 8'hf6, 8'h00);
    acc(1'h0, 8'hf8, 8'h00);
    $display("register tests done");
    tally_and_finish(1'h0);
  end
  initial #2000 tally_and_finish(1'h1);
endmodule : tb_top
